// file: common/dso_pkg.sv
// shared constants and types for the drive status output logic
package dso_pkg;
  // ==========================================================================
  // timing
  localparam int DSO_CLK_FREQ_KHZ = 250000;
  localparam int DSO_MS_PER_MS = 1;
  localparam int DSO_CYC_PER_MS = DSO_CLK_FREQ_KHZ * DSO_MS_PER_MS;
  localparam int DSO_LX_DELAY_MS = 100;
  localparam logic [5:0] DSO_DELAY_MIN = 6'h05;
  localparam logic [5:0] DSO_DELAY_MAX = 6'h32;
  localparam int DSO_NUM_TERM = 7;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] DSO_REG_MODE = 8'h00;
  localparam logic [7:0] DSO_REG_DELAY = 8'h04;
  localparam logic [7:0] DSO_REG_START_FREQ = 8'h08;
  localparam logic [7:0] DSO_REG_OL_TIMER = 8'h0C;
  localparam logic [7:0] DSO_REG_TUNE_SEL = 8'h10;
  localparam logic [7:0] DSO_REG_TUNE_TIME = 8'h14;
  localparam logic [7:0] DSO_REG_STATUS = 8'h18;
  localparam logic [7:0] DSO_REG_TERM_BASE = 8'h20;

  // ==========================================================================
  // field positions and reset values
  localparam int DSO_MODE_VECTOR_BIT = 0;
  localparam int DSO_MODE_POSITION_BIT = 1;
  localparam logic [1:0] DSO_MODE_RST = 2'h0;
  localparam logic [5:0] DSO_DELAY_RST = 6'h05;
  localparam logic [15:0] DSO_START_FREQ_RST = 16'h0000;
  localparam logic [15:0] DSO_OL_TIMER_RST = 16'h0000;
  localparam logic [1:0] DSO_TUNE_SEL_RST = 2'h0;
  localparam logic [1:0] DSO_TUNE_SEL_ONLINE = 2'h1;
  localparam logic [15:0] DSO_TUNE_TIME_RST = 16'h0000;
  localparam logic [13:0] DSO_SEL_NONE = 14'h270F;
  localparam logic [13:0] DSO_TERM0_SEL_RST = 14'h0000;

  // ==========================================================================
  // terminal selection codes
  localparam logic [13:0] DSO_SEL_RUN = 14'h0000;
  localparam logic [13:0] DSO_SEL_OL = 14'h0003;
  localparam logic [13:0] DSO_SEL_READY = 14'h000B;
  localparam logic [13:0] DSO_SEL_READY2 = 14'h0021;
  localparam logic [13:0] DSO_SEL_RUNNING_FLAG_2 = 14'h002C;
  localparam logic [13:0] DSO_SEL_RUN_OR_START_FLAG = 14'h002D;
  localparam logic [13:0] DSO_SEL_REMOTE = 14'h0060;
  localparam logic [13:0] DSO_SEL_INV_LO = 14'h0064;
  localparam logic [13:0] DSO_SEL_INV_HI = 14'h00C8;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic drive_ready;
    logic main_power;
    logic start_cmd;
    logic [15:0] out_freq;
    logic [15:0] freq_cmd;
    logic dc_brake;
    logic preexcite_cmd;
    logic output_stop_cmd;
    logic fault;
    logic other_shutoff;
    logic power_loss;
    logic restart_coast;
    logic tuning_active;
    logic overload_cond;
  } dso_drv_t;

  typedef struct packed {
    logic ol;
    logic run_or_start_flag;
    logic running_flag_2;
    logic run;
    logic ready2;
    logic ready;
  } dso_flags_t;
endpackage : dso_pkg

// file: design/dso_status_out.sv
// drive status flag generation and programmable output terminals
// Operation
// R1: terminal changes delayed by a response time of 5 to 50 ms.
// R2: terminal takes new state only after source held it for the delay.
// R3: overload warning appears after overload timer plus response delay.
// R4: controller outputs and remote outputs bypass the response filter.
// R5: ready flag on when drive ready, stays on during operation.
// R6: ready off without main power, in shutoff, or coasting with power loss.
// R7: shutoff means fault, output stop command, or other shutoff cause.
// R8: scalar modes: running flags on above start frequency, off stopped or braking.
// R9: scalar modes: run-or-start on while running or start active, off on stop.
// R10: vector modes: running off when stopped, braking, tuning or pre-exciting.
// R11: vector modes: running 2 on running or start, off on protection or stop.
// R12: vector modes: zero-speed pre-excitation sets both; running 2 off under preexcite.
// R13: vector modes: ready 2 on during pre-excitation, off during shutoff.
// R14: preexcite command gives ready 2 after 100 ms plus tuning time.
// R15: position mode servo-lock holds both running flags on; code applies it only when the vector bit is also set (mode 3), not in mode 2.
// R16: start active with zero frequency command counts as pre-excitation.
// R17: codes 11 and 33 select ready flags, plus 100 inverts.
// R18: codes 0, 44, 45 select running flags, plus 100 inverts.
// R19: inverted codes make the terminal conduct while the function is inactive.
// R20: after reset the running terminal carries positive running flag.
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/100ps
module dso_status_out
  import dso_pkg::*;
#(
  parameter int P_CYC_PER_MS = DSO_CYC_PER_MS
) (
  // clock, reset, enable
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  input wire logic I_CE,
  // register port
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  // drive state
  input wire dso_drv_t I_DRV,
  // unfiltered sources
  input wire logic [DSO_NUM_TERM-1:0] I_PLC_EN,
  input wire logic [DSO_NUM_TERM-1:0] I_PLC_OUT,
  input wire logic [DSO_NUM_TERM-1:0] I_REMOTE_OUT,
  // terminals and flags
  output logic [DSO_NUM_TERM-1:0] O_TERM,
  output dso_flags_t O_FLAGS
);

  // ==========================================================================
  // registers
  logic [1:0] mode;
  logic [5:0] resp_delay;
  logic [15:0] start_freq;
  logic [15:0] ol_timer;
  logic [1:0] tune_sel;
  logic [15:0] tune_time;
  logic [13:0] term_sel [DSO_NUM_TERM];
  logic [DSO_NUM_TERM-1:0] filt;
  logic [5:0] next_delay;
  logic vector_mode;
  logic pos_mode;

  assign vector_mode = mode[DSO_MODE_VECTOR_BIT];
  assign pos_mode = mode[DSO_MODE_POSITION_BIT];

  // out-of-range delays are clamped so the filter never runs outside its span
  always_comb begin
    next_delay = I_WDATA[5:0];
    if (I_WDATA[31:0] < 32'(DSO_DELAY_MIN)) begin
      next_delay = DSO_DELAY_MIN;
    end else if (I_WDATA[31:0] > 32'(DSO_DELAY_MAX)) begin
      next_delay = DSO_DELAY_MAX;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      mode <= DSO_MODE_RST;
      resp_delay <= DSO_DELAY_RST;
      start_freq <= DSO_START_FREQ_RST;
      ol_timer <= DSO_OL_TIMER_RST;
      tune_sel <= DSO_TUNE_SEL_RST;
      tune_time <= DSO_TUNE_TIME_RST;
    end else if (I_CE && I_WR) begin
      case (I_ADDR)
        DSO_REG_MODE: mode <= I_WDATA[1:0];
        // R1: delay range
        DSO_REG_DELAY: resp_delay <= next_delay;
        DSO_REG_START_FREQ: start_freq <= I_WDATA[15:0];
        DSO_REG_OL_TIMER: ol_timer <= I_WDATA[15:0];
        DSO_REG_TUNE_SEL: tune_sel <= I_WDATA[1:0];
        DSO_REG_TUNE_TIME: tune_time <= I_WDATA[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      O_RDATA <= 32'h00000000;
    end else if (I_CE) begin
      O_RDATA <= 32'h00000000;
      if (I_RD) begin
        if (I_ADDR >= DSO_REG_TERM_BASE && I_ADDR < DSO_REG_TERM_BASE + 8'(4 * DSO_NUM_TERM)
            && I_ADDR[1:0] == 2'h0) begin
          O_RDATA <= {18'h00000, term_sel[3'((I_ADDR - DSO_REG_TERM_BASE) >> 2)]};
        end else begin
          case (I_ADDR)
            DSO_REG_MODE: O_RDATA <= {30'h00000000, mode};
            DSO_REG_DELAY: O_RDATA <= {26'h0000000, resp_delay};
            DSO_REG_START_FREQ: O_RDATA <= {16'h0000, start_freq};
            DSO_REG_OL_TIMER: O_RDATA <= {16'h0000, ol_timer};
            DSO_REG_TUNE_SEL: O_RDATA <= {30'h00000000, tune_sel};
            DSO_REG_TUNE_TIME: O_RDATA <= {16'h0000, tune_time};
            DSO_REG_STATUS: O_RDATA <= {11'h000, filt, 1'b0, O_TERM, O_FLAGS};
            default: O_RDATA <= 32'h00000000;
          endcase
        end
      end
    end
  end

  // ==========================================================================
  // millisecond tick
  logic [31:0] tick_cnt;
  logic tick;

  assign tick = (tick_cnt == 32'(P_CYC_PER_MS - 1));

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      tick_cnt <= 32'h00000000;
    end else if (I_CE) begin
      tick_cnt <= tick ? 32'h00000000 : tick_cnt + 32'h00000001;
    end
  end

  // ==========================================================================
  // drive state decode
  logic shutoff;
  logic running;
  logic preexc_zero;
  logic coast_loss;
  logic [16:0] lx_cnt;
  logic [16:0] lx_need;
  logic lx_done;
  logic [15:0] ol_cnt;
  dso_flags_t next_flags;

  // R7: shutoff causes
  assign shutoff = I_DRV.fault | I_DRV.output_stop_cmd | I_DRV.other_shutoff;
  assign running = (I_DRV.out_freq >= start_freq) && !shutoff && !I_DRV.restart_coast;
  // R16: zero speed control
  assign preexc_zero = I_DRV.start_cmd && (I_DRV.freq_cmd == 16'h0000);
  assign coast_loss = I_DRV.restart_coast && I_DRV.power_loss;
  // R14: wait extended by tuning time only for online tuning at start
  assign lx_need = 17'(DSO_LX_DELAY_MS) + ((tune_sel == DSO_TUNE_SEL_ONLINE) ? {1'b0, tune_time} : 17'h00000);
  assign lx_done = I_DRV.preexcite_cmd && (lx_cnt >= lx_need);

  // R14: ms count since preexcite command rose, saturating
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      lx_cnt <= 17'h00000;
    end else if (I_CE) begin
      if (!I_DRV.preexcite_cmd) begin
        lx_cnt <= 17'h00000;
      end else if (tick && lx_cnt != 17'h1FFFF) begin
        lx_cnt <= lx_cnt + 17'h00001;
      end
    end
  end

  // R3: overload timer ahead of the terminal filter
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      ol_cnt <= 16'h0000;
    end else if (I_CE) begin
      if (!I_DRV.overload_cond) begin
        ol_cnt <= 16'h0000;
      end else if (tick && ol_cnt != 16'hFFFF) begin
        ol_cnt <= ol_cnt + 16'h0001;
      end
    end
  end

  always_comb begin
    next_flags = '0;
    // R5: ready while operable
    // R6: off unpowered, shut off, or coasting through power loss
    next_flags.ready = I_DRV.drive_ready && I_DRV.main_power && !shutoff && !coast_loss;
    next_flags.ol = I_DRV.overload_cond && (ol_cnt >= ol_timer);
    if (!vector_mode) begin
      // R8: scalar running flags
      next_flags.run = running && !I_DRV.dc_brake;
      next_flags.running_flag_2 = running && !I_DRV.dc_brake;
      // R9: survives faults, stop and braking while start is held
      next_flags.run_or_start_flag = running || I_DRV.start_cmd;
    end else begin
      // R10: vector running flag
      next_flags.run = running && !I_DRV.dc_brake && !I_DRV.tuning_active && !preexc_zero
                       && !I_DRV.preexcite_cmd;
      // R11: running 2 drops on protection or output stop
      // R12: zero speed counts, preexcite command does not
      next_flags.running_flag_2 = (running || I_DRV.start_cmd) && !I_DRV.fault && !I_DRV.output_stop_cmd
                        && !I_DRV.dc_brake && !I_DRV.preexcite_cmd;
      // R12: run-or-start during pre-excitation
      next_flags.run_or_start_flag = running || I_DRV.start_cmd || I_DRV.preexcite_cmd;
      // R13: ready 2 through pre-excitation, cleared in shutoff
      next_flags.ready2 = !shutoff && !I_DRV.restart_coast
                          && (preexc_zero || lx_done || running || I_DRV.dc_brake);
      // R15: servo-lock holds both running flags
      if (pos_mode && I_DRV.preexcite_cmd && !shutoff) begin
        next_flags.run = 1'b1;
        next_flags.running_flag_2 = 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      O_FLAGS <= '0;
    end else if (I_CE) begin
      O_FLAGS <= next_flags;
    end
  end

  // ==========================================================================
  // terminal selection and response filter
  function automatic logic [1:0] dso_map(input logic [13:0] sel, input dso_flags_t f, input logic rem);
    logic inv;
    logic [13:0] base;
    logic val;
    logic byp;
    inv = (sel >= DSO_SEL_INV_LO) && (sel < DSO_SEL_INV_HI);
    base = inv ? sel - DSO_SEL_INV_LO : sel;
    byp = 1'b0;
    // R17: ready codes
    // R18: running codes
    case (base)
      DSO_SEL_RUN: val = f.run;
      DSO_SEL_OL: val = f.ol;
      DSO_SEL_READY: val = f.ready;
      DSO_SEL_READY2: val = f.ready2;
      DSO_SEL_RUNNING_FLAG_2: val = f.running_flag_2;
      DSO_SEL_RUN_OR_START_FLAG: val = f.run_or_start_flag;
      DSO_SEL_REMOTE: begin
        val = rem;
        byp = 1'b1;
      end
      default: begin
        val = 1'b0;
        inv = 1'b0;
      end
    endcase
    // R19: inverted codes conduct while inactive
    dso_map = {byp, val ^ inv};
  endfunction : dso_map

  genvar t;
  generate
    for (t = 0; t < DSO_NUM_TERM; t++) begin : g_term
      logic [1:0] mapped;
      logic [5:0] hold_cnt;

      assign mapped = dso_map(term_sel[t], O_FLAGS, I_REMOTE_OUT[t]);

      always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
          // R20: running terminal defaults to positive running flag
          term_sel[t] <= (t == 0) ? DSO_TERM0_SEL_RST : DSO_SEL_NONE;
        end else if (I_CE && I_WR && I_ADDR == DSO_REG_TERM_BASE + 8'(4 * t)) begin
          term_sel[t] <= I_WDATA[13:0];
        end
      end

      // R2: new state only after holding for the full delay
      always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
          filt[t] <= 1'b0;
          hold_cnt <= 6'h00;
        end else if (I_CE) begin
          if (mapped[0] == filt[t]) begin
            hold_cnt <= 6'h00;
          end else if (tick) begin
            if (hold_cnt + 6'h01 >= resp_delay) begin
              filt[t] <= mapped[0];
              hold_cnt <= 6'h00;
            end else begin
              hold_cnt <= hold_cnt + 6'h01;
            end
          end
        end
      end

      // R4: controller and remote sources skip the filter
      always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
          O_TERM[t] <= 1'b0;
        end else if (I_CE) begin
          O_TERM[t] <= I_PLC_EN[t] ? I_PLC_OUT[t] : (mapped[1] ? mapped[0] : filt[t]);
        end
      end
    end
  endgenerate

  // ==========================================================================
  // checks
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);

  a_delay_range: assert property (resp_delay >= DSO_DELAY_MIN && resp_delay <= DSO_DELAY_MAX) // R1
    else $error("response delay outside range");
  a_filter_on_tick: assert property (!$stable(filt[0]) |-> $past(tick) && $past(I_CE)) // R2
    else $error("filtered terminal changed off a ms tick");
  a_ol_after_timer: assert property ($rose(O_FLAGS.ol) |-> $past(ol_cnt) >= $past(ol_timer)) // R3
    else $error("overload warning before timer elapsed");
  // every controller-driven terminal, not just one, so the bench's choice of terminal cannot hide a slip
  a_plc_bypass: assert property (I_CE && |I_PLC_EN // R4
                                 |=> (O_TERM & $past(I_PLC_EN)) == ($past(I_PLC_OUT) & $past(I_PLC_EN)))
    else $error("controller output did not bypass filter");
  a_shutoff_ready: assert property (I_CE && shutoff |=> !O_FLAGS.ready) // R6
    else $error("ready flag on during shutoff");
  a_scalar_run_or_start_flag: assert property (I_CE && !vector_mode && I_DRV.start_cmd |=> O_FLAGS.run_or_start_flag && !O_FLAGS.ready2) // R9
    else $error("scalar run-or-start flag wrong");
  a_vector_stop_running_flag_2: assert property (I_CE && vector_mode && I_DRV.output_stop_cmd && !pos_mode // R11
                                       |=> !O_FLAGS.running_flag_2)
    else $error("running 2 on with output stop");
  a_vector_shut_ready2: assert property (I_CE && vector_mode && shutoff |=> !O_FLAGS.ready2) // R13
    else $error("ready 2 on during shutoff");
  // only the preexcite wait is left as a cause, so an early ready 2 shows up here
  a_lx_wait: assert property ($rose(O_FLAGS.ready2) && $past(I_DRV.preexcite_cmd) && !$past(preexc_zero) // R14
                              && !$past(running) && !$past(I_DRV.dc_brake) |-> $past(lx_cnt) >= $past(lx_need))
    else $error("ready 2 raised before preexcite wait");
  a_servo_lock: assert property (I_CE && vector_mode && pos_mode && I_DRV.preexcite_cmd && !shutoff // R15
                                 |=> O_FLAGS.run && O_FLAGS.running_flag_2)
    else $error("servo-lock did not hold running flags");
  a_ready_unpowered: assert property (I_CE && !I_DRV.main_power |=> !O_FLAGS.ready) // R6
    else $error("ready flag on without main power");
  a_scalar_brake_run: assert property (I_CE && !vector_mode && I_DRV.dc_brake |=> !O_FLAGS.run && !O_FLAGS.running_flag_2) // R8
    else $error("scalar running flags on during braking");
  a_vector_lx_run: assert property (I_CE && vector_mode && !pos_mode && I_DRV.preexcite_cmd // R12
                                    |=> !O_FLAGS.run && !O_FLAGS.running_flag_2)
    else $error("running flags on under preexcite command");

  c_term_change: cover property (!$stable(filt[0]));
  c_lx_ready2: cover property ($rose(O_FLAGS.ready2) && I_DRV.preexcite_cmd);
  c_ol_warn: cover property ($rose(O_FLAGS.ol));
  c_zero_speed: cover property (vector_mode && O_FLAGS.running_flag_2 && !O_FLAGS.run && O_FLAGS.ready2);

endmodule : dso_status_out

// file: test/dso_term_load.sv
// load model standing on the output terminals: relay coil or opto input
`timescale 1ns/100ps
module dso_term_load
  import dso_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // terminals from the drive
  input wire logic [DSO_NUM_TERM-1:0] i_term,
  // what the load saw
  output logic [DSO_NUM_TERM-1:0] o_energised,
  output int o_toggles [DSO_NUM_TERM]
);
  // ==========
  // contact state
  // no bounce is modelled, so every counted toggle is a real terminal change
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_energised <= '0;
      for (int i = 0; i < DSO_NUM_TERM; i++) begin
        o_toggles[i] <= 0;
      end
    end else begin
      o_energised <= i_term;
      for (int i = 0; i < DSO_NUM_TERM; i++) begin
        if (i_term[i] != o_energised[i]) begin
          o_toggles[i] <= o_toggles[i] + 1;
        end
      end
    end
  end
endmodule : dso_term_load

// file: test/dso_status_out_bench.sv
// self-checking bench for the drive status output logic
`timescale 1ns/100ps
module dso_status_out_bench;
  import dso_pkg::*;
  // short ms tick keeps the 100 ms counts affordable
  localparam int CPM = 4;
  logic clk;
  logic rst_n;
  logic ce;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  dso_drv_t drv;
  logic [DSO_NUM_TERM-1:0] plc_en;
  logic [DSO_NUM_TERM-1:0] plc_out;
  logic [DSO_NUM_TERM-1:0] rem_out;
  logic [DSO_NUM_TERM-1:0] term;
  dso_flags_t flags;
  logic [DSO_NUM_TERM-1:0] relay;
  int toggles [DSO_NUM_TERM];
  int fail_count;
  int n_checks;

  dso_status_out #(.P_CYC_PER_MS(CPM)) u_dso_status_out (
    .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_CE(ce), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_DRV(drv), .I_PLC_EN(plc_en), .I_PLC_OUT(plc_out),
    .I_REMOTE_OUT(rem_out), .O_TERM(term), .O_FLAGS(flags));
  dso_term_load u_dso_term_load (.i_clk(clk), .i_rst_n(rst_n), .i_term(term), .o_energised(relay),
    .o_toggles(toggles));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========
  // helpers
  task automatic finish_test();
    if (fail_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic apply(input dso_drv_t d);
    @(posedge clk);
    drv <= d;
    @(posedge clk);
    #1;
  endtask : apply

  function automatic logic probe(input int sel);
    return (sel < DSO_NUM_TERM) ? term[sel] : flags.ready2;
  endfunction : probe

  task automatic wait_for(input int sel, input logic val, output int n);
    n = 0;
    while (probe(sel) !== val) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 2000) begin
        check("wait_bound", 32'h0, 32'h1);
        finish_test();
      end
    end
  endtask : wait_for

  function automatic logic [31:0] win(input int n, input int lo, input int hi);
    return {31'h0, n >= lo && n <= hi};
  endfunction : win

  // bits: start, dc brake, stop, fault, tuning, preexcite, overload
  function automatic dso_drv_t mk(input logic [6:0] f, input logic [15:0] of);
    dso_drv_t d;
    d = '0;
    d.drive_ready = 1'b1;
    d.main_power = 1'b1;
    d.start_cmd = f[0];
    d.dc_brake = f[1];
    d.output_stop_cmd = f[2];
    d.fault = f[3];
    d.tuning_active = f[4];
    d.preexcite_cmd = f[5];
    d.overload_cond = f[6];
    d.out_freq = of;
    d.freq_cmd = of;
    return d;
  endfunction : mk

  // scalar flags {run_or_start_flag, running_flag_2, run, ready2, ready}, start frequency 0x100
  function automatic logic [4:0] exp_scalar(input dso_drv_t d);
    logic shut;
    logic mov;
    logic run;
    logic rdy;
    shut = d.fault | d.output_stop_cmd | d.other_shutoff;
    // run-or-start stays on through dc braking, the running flags do not
    mov = (d.out_freq >= 16'h0100) & !shut & !d.restart_coast;
    run = mov & !d.dc_brake;
    rdy = d.drive_ready & d.main_power & !shut & !(d.restart_coast & d.power_loss);
    return {mov | d.start_cmd, run, run, 1'b0, rdy};
  endfunction : exp_scalar

  // ==========
  // main sequence
  initial begin
    logic [31:0] v;
    logic [31:0] r;
    int n;
    dso_drv_t d;
    logic [13:0] codes [5];
    logic ex [5];
    logic [6:0] vf [5];
    logic [4:0] ve [5];
    codes = '{14'h0000, 14'h000B, 14'h0021, 14'h002C, 14'h002D};
    ex = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    vf = '{7'h01, 7'h09, 7'h11, 7'h03, 7'h05};
    ve = '{5'h1B, 5'h10, 5'h1B, 5'h13, 5'h10};
    fail_count = 0;
    n_checks = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    drv = '0;
    plc_en = '0;
    plc_out = '0;
    rem_out = '0;
    void'($urandom(32'hF979AB5B));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(DSO_REG_DELAY, v);
    check("delay_rst", v, 32'h5);
    rd_reg(DSO_REG_TERM_BASE, v);
    check("term0_sel_rst", v, 32'h0);
    rd_reg(8'hFC, v);
    check("unmapped", v, 32'h0);
    wr_reg(DSO_REG_DELAY, 32'h2);
    rd_reg(DSO_REG_DELAY, v);
    check("delay_lo", v, 32'h5);
    wr_reg(DSO_REG_DELAY, 32'h3C);
    rd_reg(DSO_REG_DELAY, v);
    check("delay_hi", v, 32'h32);
    wr_reg(DSO_REG_DELAY, 32'h5);
    wr_reg(DSO_REG_START_FREQ, 32'h100);
    // shutoff causes biased low so that ready and running show up often
    for (int i = 0; i < 48; i++) begin
      r = $urandom();
      d = '0;
      d.drive_ready = |r[1:0];
      d.main_power = |r[3:2];
      d.start_cmd = r[4];
      d.dc_brake = &r[6:5];
      d.output_stop_cmd = &r[8:7];
      d.fault = &r[10:9];
      d.other_shutoff = &r[12:11];
      d.power_loss = r[13];
      d.restart_coast = &r[15:14];
      d.out_freq = {7'h0, r[24:16]};
      d.freq_cmd = {9'h0, r[31:25]};
      if (i == 0) d = mk(7'h00, 16'h0100);
      apply(d);
      check("flags_scalar", {27'h0, flags[4:0]}, {27'h0, exp_scalar(d)});
    end
    apply(mk(7'h01, 16'h0200));
    for (int i = 0; i < 10; i++) begin
      wr_reg(DSO_REG_TERM_BASE + 8'h04, 32'(codes[i % 5]) + 32'(100 * (i / 5)));
      repeat (7 * CPM) @(posedge clk);
      #1;
      check("term1_map", {31'h0, term[1]}, {31'h0, ex[i % 5] ^ (i >= 5)});
    end
    wr_reg(DSO_REG_DELAY, 32'hA);
    repeat (12 * CPM) @(posedge clk);
    n = toggles[0];
    apply(mk(7'h00, 16'h0000));
    repeat (2 * CPM) @(posedge clk);
    apply(mk(7'h01, 16'h0200));
    repeat (12 * CPM) @(posedge clk);
    #1;
    check("glitch", 32'(toggles[0] - n), 32'h0);
    check("term0_run", {31'h0, relay[0]}, 32'h1);
    apply(mk(7'h00, 16'h0000));
    wait_for(0, 1'b0, n);
    check("resp_delay", win(n, 9 * CPM, 11 * CPM + 2), 32'h1);
    wr_reg(DSO_REG_TERM_BASE + 8'h0C, 32'h60);
    @(posedge clk);
    rem_out <= 7'h08;
    plc_en <= 7'h04;
    plc_out <= 7'h04;
    @(posedge clk);
    #1;
    check("bypass", {25'h0, term & 7'h0C}, 32'hC);
    wr_reg(DSO_REG_TERM_BASE + 8'h0C, 32'hC4);
    plc_out <= 7'h00;
    @(posedge clk);
    #1;
    check("bypass_inv", {25'h0, term & 7'h0C}, 32'h0);
    wr_reg(DSO_REG_OL_TIMER, 32'h3);
    wr_reg(DSO_REG_TERM_BASE + 8'h10, 32'h3);
    apply(mk(7'h40, 16'h0000));
    wait_for(4, 1'b1, n);
    check("ol_delay", win(n, 11 * CPM, 14 * CPM + 4), 32'h1);
    apply(mk(7'h00, 16'h0000));
    wr_reg(DSO_REG_MODE, 32'h1);
    for (int i = 0; i < 5; i++) begin
      apply(mk(vf[i], (i < 2) ? 16'h0000 : 16'h0200));
      check("flags_vector", {27'h0, flags[4:0]}, {27'h0, ve[i]});
    end
    for (int s = 0; s < 2; s++) begin
      wr_reg(DSO_REG_TUNE_SEL, 32'(s));
      wr_reg(DSO_REG_TUNE_TIME, 32'h14);
      apply(mk(7'h00, 16'h0000));
      wait_for(7, 1'b0, n);
      apply(mk(7'h20, 16'h0000));
      check("lx_run", {30'h0, flags.running_flag_2, flags.run}, 32'h0);
      wait_for(7, 1'b1, n);
      check("lx_ready2", win(n, (99 + 20 * s) * CPM, (101 + 20 * s) * CPM + 2), 32'h1);
    end
    wr_reg(DSO_REG_MODE, 32'h3);
    apply(mk(7'h20, 16'h0000));
    check("servo_lock", {30'h0, flags.running_flag_2, flags.run}, 32'h3);
    rd_reg(DSO_REG_STATUS, v);
    check("status_flags", v & 32'h3F, 32'h1F);
    // enable low must freeze the flags even though the drive has stopped
    @(posedge clk);
    ce <= 1'b0;
    drv <= mk(7'h00, 16'h0000);
    repeat (3) @(posedge clk);
    #1;
    check("ce_freeze", {30'h0, flags.running_flag_2, flags.run}, 32'h3);
    finish_test();
  end
endmodule : dso_status_out_bench
